// [rtl/angle_out_defs.vh]
// constants for the angle output block: resolution codes, spacing, monoflop
// assumes a 200 MHz core clock (5 ns period)
`ifndef ANGLE_OUT_DEFS_VH
`define ANGLE_OUT_DEFS_VH

`define CLK_PERIOD_PS 5000
// resolution select codes 0..8 binary 8192..32, 9..20 decimal 2000..40
`define RES_SEL_W 5
`define RES_CODE_COUNT 21
`define ANGLE_W 13
// minimum transition spacing in ps per code, rounded up to whole cycles
`define SPACING_CYC(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SPACING_W 13
// monoflop: 1024 oscillator cycles, shortest case 12.5 us
`define MONOFLOP_NS 12500
// 12.5 us at 5 ns per cycle, sized to the monoflop counter
`define MONOFLOP_CYC 12'h9C4
`define MONOFLOP_W 12
// hysteresis select 0..5 -> 0,1,2,4,8,16 units of 1/4096 turn
`define HYST_SEL_W 3
`define FRAC_W 16

`endif

// [rtl/word_skid.v]
// two-entry buffer with valid/ready on both sides
// assumes the same clock and asynchronous active-low reset on both sides
`timescale 1ns/1ps
module word_skid (
	// clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// fill side
	input wire in_valid_in,
	input wire [12:0] in_data_in,
	output wire in_ready_out,
	// drain side
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [12:0] out_data_out
);
	reg [12:0] mem_r [0:1];
	reg wr_ptr_r;
	reg rd_ptr_r;
	reg [1:0] count_r;
	wire push = in_valid_in && (count_r != 2'h2);
	wire pop = out_ready_in && (count_r != 2'h0);

	assign in_ready_out = (count_r != 2'h2);
	assign out_valid_out = (count_r != 2'h0);
	assign out_data_out = mem_r[rd_ptr_r];

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
			mem_r[0] <= 13'h0000;
			mem_r[1] <= 13'h0000;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= in_data_in;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // word_skid

// [rtl/angle_ssi_quadrature_out.v]
// angle output: hysteresis, resolution scaling, quadrature with reference
// mark, and SSI slave with monoflop and optional ring mode.
// assumes a 16-bit raw angle from the interpolator core on clk_in and a
// serial clock pin from the far side, sampled through two flip-flops.
`timescale 1ns/1ps
`include "angle_out_defs.vh"

module angle_ssi_quadrature_out (
	// clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// raw angle from interpolator, full turn = 2^16
	input wire [15:0] raw_angle_in,
	// configuration straps
	input wire [4:0] res_sel_in,
	input wire [2:0] hyst_sel_in,
	input wire dir_negative_in,
	input wire ring_mode_in,
	// serial link
	input wire ssi_clk_in,
	output wire ssi_data_out,
	// incremental outputs
	output reg quad_a_out,
	output reg quad_b_out,
	output reg reference_mark_out,
	// snapshot stream to core side
	output wire pos_valid_out,
	input wire pos_ready_in,
	output wire [12:0] pos_data_out
);
	// counts_per_revolution per code
	function [12:0] counts_per_revolution;
		input [4:0] c;
		begin
			case (c)
			5'h00: counts_per_revolution = 13'h1FFF;
			5'h01: counts_per_revolution = 13'h1000;
			5'h02: counts_per_revolution = 13'h0800;
			5'h03: counts_per_revolution = 13'h0400;
			5'h04: counts_per_revolution = 13'h0200;
			5'h05: counts_per_revolution = 13'h0100;
			5'h06: counts_per_revolution = 13'h0080;
			5'h07: counts_per_revolution = 13'h0040;
			5'h08: counts_per_revolution = 13'h0020;
			5'h09: counts_per_revolution = 13'h07D0;
			5'h0A: counts_per_revolution = 13'h0640;
			5'h0B: counts_per_revolution = 13'h03E8;
			5'h0C: counts_per_revolution = 13'h0320;
			5'h0D: counts_per_revolution = 13'h01F4;
			5'h0E: counts_per_revolution = 13'h0190;
			5'h0F: counts_per_revolution = 13'h0140;
			5'h10: counts_per_revolution = 13'h00C8;
			5'h11: counts_per_revolution = 13'h00A0;
			5'h12: counts_per_revolution = 13'h0064;
			5'h13: counts_per_revolution = 13'h0050;
			default: counts_per_revolution = 13'h0028;
			endcase
		end
	endfunction

	// min_transition_spacing per code, in core cycles
	function [31:0] min_transition_spacing;
		input [4:0] c;
		begin
			case (c)
			5'h00: min_transition_spacing = `SPACING_CYC(122000);
			5'h01: min_transition_spacing = `SPACING_CYC(146000);
			5'h02: min_transition_spacing = `SPACING_CYC(293000);
			5'h03: min_transition_spacing = `SPACING_CYC(585000);
			5'h04: min_transition_spacing = `SPACING_CYC(1170000);
			5'h05: min_transition_spacing = `SPACING_CYC(2340000);
			5'h06: min_transition_spacing = `SPACING_CYC(4680000);
			5'h07: min_transition_spacing = `SPACING_CYC(9360000);
			5'h08: min_transition_spacing = `SPACING_CYC(18800000);
			5'h09: min_transition_spacing = `SPACING_CYC(293000);
			5'h0A: min_transition_spacing = `SPACING_CYC(390000);
			5'h0B: min_transition_spacing = `SPACING_CYC(585000);
			5'h0C: min_transition_spacing = `SPACING_CYC(780000);
			5'h0D: min_transition_spacing = `SPACING_CYC(1260000);
			5'h0E: min_transition_spacing = `SPACING_CYC(1560000);
			5'h0F: min_transition_spacing = `SPACING_CYC(1950000);
			5'h10: min_transition_spacing = `SPACING_CYC(3120000);
			5'h11: min_transition_spacing = `SPACING_CYC(3900000);
			5'h12: min_transition_spacing = `SPACING_CYC(6240000);
			5'h13: min_transition_spacing = `SPACING_CYC(7800000);
			default: min_transition_spacing = `SPACING_CYC(15600000);
			endcase
		end
	endfunction

	// reset release through two flops
	reg rst_s1_r;
	reg rst_n_r;
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// configuration captured once after reset, never changed later
	reg cfg_done_r;
	reg [4:0] res_r;
	reg [2:0] hyst_r;
	reg neg_r;
	reg ring_r;
	always @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cfg_done_r <= 1'b0;
			res_r <= 5'h00;
			hyst_r <= 3'h2;
			neg_r <= 1'b0;
			ring_r <= 1'b0;
		end else if (!cfg_done_r) begin
			cfg_done_r <= 1'b1;
			res_r <= (res_sel_in > 5'h14) ? 5'h14 : res_sel_in;
			hyst_r <= (hyst_sel_in > 3'h5) ? 3'h5 : hyst_sel_in;
			neg_r <= dir_negative_in;
			ring_r <= ring_mode_in;
		end
	end

	// hysteresis in units of 1/65536 turn: 0 or 16<<(sel-1)
	wire [15:0] hyst_w = (hyst_r == 3'h0) ? 16'h0000 :
		(16'h0010 << (hyst_r - 3'h1));
	// direction applied before quantising so serial and quadrature agree
	wire [15:0] dir_angle_w = neg_r ? (16'h0000 - raw_angle_in) :
		raw_angle_in;
	reg [15:0] held_r;
	wire [15:0] diff_w = dir_angle_w - held_r;
	always @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r)
			held_r <= 16'h0000;
		else if (!cfg_done_r)
			held_r <= 16'h0000;
		else if (diff_w[15] ? ((16'h0000 - diff_w) > hyst_w) :
			(diff_w > hyst_w))
			held_r <= dir_angle_w;
	end

	// quantise: target = held * cpr / 65536 ; code 0 is 8192 counts
	wire [12:0] cpr_w = counts_per_revolution(res_r);
	wire [13:0] cpr_full_w = (res_r == 5'h00) ? 14'h2000 : {1'b0, cpr_w};
	wire [29:0] prod_w = held_r * cpr_full_w;
	wire [12:0] target_w = prod_w[28:16];
	wire [12:0] cpr_max_w = cpr_full_w[12:0] - 13'h0001;

	// output position walks toward target one step at a time
	reg [12:0] pos_r;
	reg [12:0] gap_r;
	wire [12:0] fwd_w = (target_w >= pos_r) ? (target_w - pos_r) :
		(target_w + cpr_full_w[12:0] - pos_r);
	wire step_w = (pos_r != target_w) && (gap_r == 13'h0000);
	// half a turn taken from the 14-bit count so code 0 is not zero
	wire up_w = (fwd_w <= cpr_full_w[13:1]);
	wire [31:0] spacing_w = min_transition_spacing(res_r);
	wire [12:0] pos_nxt = up_w ?
		((pos_r == cpr_max_w) ? 13'h0000 : pos_r + 13'h0001) :
		((pos_r == 13'h0000) ? cpr_max_w : pos_r - 13'h0001);
	always @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pos_r <= 13'h0000;
			gap_r <= 13'h0000;
		end else if (step_w) begin
			pos_r <= pos_nxt;
			gap_r <= spacing_w[12:0] - 13'h0001;
		end else if (gap_r != 13'h0000) begin
			gap_r <= gap_r - 13'h0001;
		end
	end

	// quadrature: B leads A as position rises; mark at position 0
	always @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			quad_a_out <= 1'b0;
			quad_b_out <= 1'b0;
			reference_mark_out <= 1'b1;
		end else begin
			quad_b_out <= pos_r[1] ^ pos_r[0];
			quad_a_out <= pos_r[1];
			reference_mark_out <= (pos_r == 13'h0000);
		end
	end

	// serial clock pin: two flops, then edge detect on the second
	reg sck_s1_r;
	reg sck_s2_r;
	reg sck_d_r;
	always @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sck_s1_r <= 1'b1;
			sck_s2_r <= 1'b1;
			sck_d_r <= 1'b1;
		end else begin
			sck_s1_r <= ssi_clk_in;
			sck_s2_r <= sck_s1_r;
			sck_d_r <= sck_s2_r;
		end
	end
	wire fall_w = sck_d_r && !sck_s2_r;
	wire rise_w = !sck_d_r && sck_s2_r;

	// SSI states
	localparam ST_IDLE = 2'h0;
	localparam ST_ARMED = 2'h1;
	localparam ST_SHIFT = 2'h2;
	localparam ST_DONE = 2'h3;
	reg [1:0] state_r;
	reg [12:0] shift_r;
	reg [12:0] word_r;
	reg [3:0] bit_r;
	reg data_r;
	reg [11:0] mono_r;
	reg snap_r;
	// count after the LSB went out: 13 bits sent on rises 1..13
	wire [3:0] top_bit_w = 4'hD;
	always @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ST_IDLE;
			shift_r <= 13'h0000;
			word_r <= 13'h0000;
			bit_r <= 4'h0;
			data_r <= 1'b1;
			mono_r <= 12'h000;
			snap_r <= 1'b0;
		end else begin
			snap_r <= 1'b0;
			if (fall_w || rise_w)
				mono_r <= `MONOFLOP_CYC;
			else if (mono_r != 12'h000)
				mono_r <= mono_r - 12'h001;
			case (state_r)
			ST_IDLE: begin
				data_r <= 1'b1;
				if (fall_w) begin
					word_r <= pos_r;
					shift_r <= pos_r;
					snap_r <= 1'b1;
					state_r <= ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (rise_w) begin
					data_r <= shift_r[12];
					shift_r <= {shift_r[11:0], 1'b0};
					bit_r <= 4'h1;
					state_r <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (rise_w) begin
					if (bit_r == top_bit_w + 4'h1) begin
						data_r <= shift_r[12];
						shift_r <= {shift_r[11:0], 1'b0};
						bit_r <= 4'h1;
					end else if (bit_r == top_bit_w) begin
						data_r <= 1'b0;
						shift_r <= word_r;
						bit_r <= bit_r + 4'h1;
						if (!ring_r)
							state_r <= ST_DONE;
					end else begin
						data_r <= shift_r[12];
						shift_r <= {shift_r[11:0], 1'b0};
						bit_r <= bit_r + 4'h1;
					end
				end
			end
			ST_DONE: data_r <= 1'b0;
			default: state_r <= ST_IDLE;
			endcase
			// monoflop expiry ends any read and lets data rise
			if (state_r != ST_IDLE && mono_r == 12'h001 &&
				!(fall_w || rise_w)) begin
				state_r <= ST_IDLE;
				data_r <= 1'b1;
			end
		end
	end
	assign ssi_data_out = data_r;

	// latched words offered downstream; stall never blocks the read
	word_skid u_skid (
		.clk_in(clk_in),
		.rst_n_in(rst_n_r),
		.in_valid_in(snap_r),
		.in_data_in(word_r),
		.in_ready_out(),
		.out_valid_out(pos_valid_out),
		.out_ready_in(pos_ready_in),
		.out_data_out(pos_data_out)
	);
endmodule // angle_ssi_quadrature_out

// [tb/angle_out_checker_sva.sv]
// checker for the angle output block: serial timing, quadrature, stream
// assumes the bench idles the serial clock high and holds straps after reset
`timescale 1ns/1ps
module angle_out_checker (
	// clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// straps and serial link
	input wire [4:0] res_sel_in,
	input wire ssi_clk_in,
	input wire ssi_data_out,
	// incremental outputs
	input wire quad_a_out,
	input wire quad_b_out,
	input wire reference_mark_out,
	// snapshot stream
	input wire pos_valid_out,
	input wire pos_ready_in,
	input wire [12:0] pos_data_out
);
	reg last_clk_r;
	reg [11:0] since_r;
	reg [1:0] last_ab_r;
	reg [7:0] gap_r;
	wire [7:0] min_gap;
	// one short: gap_r counts the edges strictly between two steps
	assign min_gap = (res_sel_in == 5'h00) ? 8'h18 :
		(res_sel_in == 5'h01) ? 8'h1D : (res_sel_in == 5'h09) ? 8'h3A : 8'h00;
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_clk_r <= 1'b1;
			since_r <= 12'hFFF;
			last_ab_r <= 2'h0;
			gap_r <= 8'hFF;
		end else begin
			last_clk_r <= ssi_clk_in;
			last_ab_r <= {quad_a_out, quad_b_out};
			if (ssi_clk_in != last_clk_r)
				since_r <= 12'h000;
			else if (since_r != 12'hFFF)
				since_r <= since_r + 12'h001;
			if ({quad_a_out, quad_b_out} != last_ab_r)
				gap_r <= 8'h00;
			else if (gap_r != 8'hFF)
				gap_r <= gap_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_idle_fall;
		since_r >= 12'hA28 && $fell(ssi_clk_in);
	endsequence
	sequence s_bit_slot;
		ssi_clk_in && since_r >= 12'h001 && since_r <= 12'h007;
	endsequence
	sequence s_expiry;
		since_r >= 12'h9BA && ssi_data_out;
	endsequence
	property p_gray;
		$changed(quad_a_out) |-> $stable(quad_b_out);
	endproperty
	a_gray: assert property (p_gray) else $error("both channels moved");
	property p_spacing;
		$changed({quad_a_out, quad_b_out}) |-> gap_r >= min_gap;
	endproperty
	a_spacing: assert property (p_spacing) else $error("steps too close");
	property p_mark;
		reference_mark_out |-> !quad_a_out && !quad_b_out;
	endproperty
	a_mark: assert property (p_mark) else $error("mark off zero");
	property p_data_slot;
		$changed(ssi_data_out) |-> s_bit_slot or s_expiry;
	endproperty
	a_data_slot: assert property (p_data_slot) else $error("data moved");
	property p_expire;
		since_r >= 12'hA28 |-> ssi_data_out;
	endproperty
	a_expire: assert property (p_expire) else $error("data not idle");
	property p_latch;
		s_idle_fall |-> ##[1:6] pos_valid_out;
	endproperty
	a_latch: assert property (p_latch) else $error("no snapshot");
	property p_hold;
		pos_valid_out && !pos_ready_in |=> pos_valid_out && $stable(pos_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled word lost");
	property p_rise_cause;
		$rose(pos_valid_out) |-> !ssi_clk_in && since_r <= 12'h006;
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("stray word");
endmodule // angle_out_checker

bind angle_ssi_quadrature_out angle_out_checker chk_i (.clk_in, .reset_n_in,
	.res_sel_in, .ssi_clk_in, .ssi_data_out, .quad_a_out, .quad_b_out,
	.reference_mark_out, .pos_valid_out, .pos_ready_in, .pos_data_out);

// [tb/motion_ctrl.sv]
// controller model: serial master and quadrature up/down counter
// assumes read_bits is entered just after a falling clk_in edge
`timescale 1ns/1ps
module motion_ctrl (
	// clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// from the encoder
	input wire ssi_data_in,
	input wire quad_a_in,
	input wire quad_b_in,
	// serial clock to the encoder
	output reg ssi_clk_out
);
	integer count;
	reg [1:0] phase_r;
	wire [1:0] phase;
	assign phase = {quad_a_in, quad_a_in ^ quad_b_in};
	initial ssi_clk_out = 1'b1;
	// a skipped phase is not counted, so a missed step shows in the total
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= 0;
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase;
			if (phase == phase_r + 2'h1)
				count <= count + 1;
			else if (phase == phase_r - 2'h1)
				count <= count - 1;
		end
	end
	// 80 ns period, clock stands high between frames
	task read_bits(input integer n, output reg [31:0] w);
		integer i;
		begin
			w = 32'h0;
			for (i = 0; i < n; i = i + 1) begin
				ssi_clk_out = 1'b0;
				#40;
				ssi_clk_out = 1'b1;
				#40;
				w = {w[30:0], ssi_data_in};
			end
		end
	endtask
endmodule // motion_ctrl

// [tb/tb.sv]
// bench for the angle output block: three strap sets, reads and counts
// assumes the checker is bound in and the controller model drives the link
`timescale 1ns/1ps
module tb;
	reg clk_in;
	reg reset_n_in;
	reg [15:0] raw_angle_in;
	reg [4:0] res_sel_in;
	reg [2:0] hyst_sel_in;
	reg dir_negative_in;
	reg ring_mode_in;
	reg pos_ready_in;
	wire ssi_clk_in;
	wire ssi_data_out;
	wire quad_a_out;
	wire quad_b_out;
	wire reference_mark_out;
	wire pos_valid_out;
	wire [12:0] pos_data_out;
	reg [31:0] w;
	integer miscompares;
	integer n_checks;
	integer cycles;
	angle_ssi_quadrature_out dut (.clk_in, .reset_n_in, .raw_angle_in,
		.res_sel_in, .hyst_sel_in, .dir_negative_in, .ring_mode_in,
		.ssi_clk_in, .ssi_data_out, .quad_a_out, .quad_b_out,
		.reference_mark_out, .pos_valid_out, .pos_ready_in, .pos_data_out);
	motion_ctrl ctl (.clk_in, .reset_n_in, .ssi_data_in(ssi_data_out),
		.quad_a_in(quad_a_out), .quad_b_in(quad_b_out),
		.ssi_clk_out(ssi_clk_in));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input [31:0] exp, input [31:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("mismatch at %0t exp %h got %h", $time, exp, got);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk_in);
	endtask
	// straps are only taken at reset release
	task boot(input [4:0] res, input neg, input ring);
		begin
			reset_n_in = 1'b0;
			res_sel_in = res;
			dir_negative_in = neg;
			ring_mode_in = ring;
			raw_angle_in = 16'h0000;
			cyc(5);
			reset_n_in = 1'b1;
			cyc(10);
		end
	endtask
	task read_chk(input integer n, input [31:0] exp);
		begin
			ctl.read_bits(n, w);
			chk(exp, w);
			cyc(2700);
		end
	endtask
	always @(posedge clk_in) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end
	initial begin
		miscompares = 0;
		n_checks = 0;
		cycles = 0;
		hyst_sel_in = 3'h0;
		pos_ready_in = 1'b0;
		boot(5'h00, 1'b0, 1'b0);
		ring_mode_in = 1'b1;
		raw_angle_in = 16'h0028;
		cyc(200);
		chk(32'h5, ctl.count);
		ctl.read_bits(16, w);
		chk(32'h28, w);
		cyc(2000);
		chk(32'h0, ssi_data_out);
		cyc(700);
		chk(32'h1, ssi_data_out);
		raw_angle_in = 16'h0038;
		cyc(100);
		read_chk(13, 32'h7);
		raw_angle_in = 16'h0010;
		cyc(200);
		chk(32'h2, ctl.count);
		read_chk(13, 32'h2);
		chk(32'h1, pos_valid_out);
		chk(32'h5, pos_data_out);
		pos_ready_in = 1'b1;
		cyc(1);
		pos_ready_in = 1'b0;
		chk(32'h7, pos_data_out);
		pos_ready_in = 1'b1;
		cyc(1);
		pos_ready_in = 1'b0;
		chk(32'h0, pos_valid_out);
		raw_angle_in = 16'h0000;
		cyc(100);
		chk(32'h1, reference_mark_out);
		chk(32'h0, {quad_a_out, quad_b_out});
		boot(5'h00, 1'b1, 1'b1);
		pos_ready_in = 1'b1;
		raw_angle_in = 16'h0028;
		cyc(200);
		chk(32'hFFFF_FFFB, ctl.count);
		read_chk(27, 32'h07FE_DFFB);
		boot(5'h09, 1'b0, 1'b0);
		raw_angle_in = 16'h0064;
		cyc(300);
		chk(32'h3, ctl.count);
		read_chk(13, 32'h3);
		report_and_stop;
	end
endmodule // tb
